// *** rtl/cltd_pkg.sv ***
// Package for the control, literal and table instruction decoder
package cltd_pkg;

  // Opcode fields
  localparam logic [3:0] OP_SECOND_WORD = 4'h f;
  localparam logic [6:0] OP_CALL_HI = 7'h76;
  localparam logic [4:0] OP_BRANCH_HI = 5'h1c;
  localparam logic [15:0] OP_NO_OPERATION = 16'h0000;
  localparam logic [15:0] OP_SLEEP = 16'h0003;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [14:0] OP_IRQ_RETURN_HI = 15'h0008;
  localparam logic [14:0] OP_RETURN_HI = 15'h0009;
  // Table read and write share the top thirteen bits
  localparam logic [12:0] OP_TABLE_HI = 13'h0001;
  localparam logic [7:0] OP_RETURN_LITERAL = 8'h0c;
  localparam logic [7:0] OP_AND_LITERAL = 8'h0b;
  localparam logic [7:0] OP_OR_LITERAL = 8'h09;
  localparam logic [7:0] OP_XOR_LITERAL = 8'h0a;
  localparam logic [7:0] OP_SUB_LITERAL = 8'h08;
  localparam logic [7:0] OP_MUL_LITERAL = 8'h0d;
  localparam logic [7:0] OP_LOAD_LITERAL = 8'h0e;
  localparam logic [7:0] TIMER_ZERO_ADDR = 8'hd6;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;

  // Flag positions in the affected-flags mask
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_TIMEOUT = 5;
  localparam int FLAG_POWER_DOWN = 6;
  localparam int FLAG_IRQ = 7;

  typedef enum logic [4:0] {
    CLTD_NO_OPERATION, CLTD_CALL, CLTD_BRANCH, CLTD_POP, CLTD_PUSH,
    CLTD_RETURN_FROM_INTERRUPT, CLTD_RETURN, CLTD_RETURN_WITH_LITERAL,
    CLTD_STANDBY, CLTD_AND_LITERAL, CLTD_OR_LITERAL, CLTD_XOR_LITERAL,
    CLTD_SUBTRACT_FROM_LITERAL, CLTD_MULTIPLY_LITERAL, CLTD_LOAD_LITERAL,
    CLTD_TABLE_READ, CLTD_TABLE_WRITE
  } cltd_op_t;

  typedef enum logic [1:0] {
    CLTD_PTR_NONE, CLTD_PTR_POST_INC, CLTD_PTR_POST_DEC, CLTD_PTR_PRE_INC
  } cltd_ptr_t;

  typedef struct packed {
    cltd_op_t op;
    logic [1:0] cycles;
    logic [7:0] flags;
    logic [7:0] literal;
    logic shadow;
    cltd_ptr_t ptr_mode;
    logic [19:0] target;
    logic irq_reenable;
  } cltd_dec_t;

endpackage : cltd_pkg

// *** rtl/cltd_decoder.sv ***
// Control, literal and table instruction decoder
// Function
// - Call is two words, s selects shadow save, 20-bit target, 2 cycles
// - A lone second word (top nibble 1111) runs as no-operation
// - PC change or true conditional test costs two cycles, second is idle
// - 0x0006 pops the return stack in one cycle, no flags
// - 0x0005 pushes the return stack in one cycle, no flags
// - 0x0010/0x0011 returns from interrupt in 2 cycles, re-enables interrupts
// - 0x0012/0x0013 returns from subroutine in 2 cycles, s restores shadows
// - 0x0Ckk loads literal and returns, 2 cycles, no flags
// - 0x0003 enters standby in one cycle, updates timeout and power-down
// - 0x0B/09/0A: AND, OR, XOR literal, one cycle, Z and N
// - 0x08: subtract working register from literal, all arithmetic flags
// - 0x0D: multiply literal by working register, one cycle, no flags
// - 0x0E: load literal into working register, one cycle, no flags
// - 0x0008-0x000B table read, 2 cycles, four pointer modes
// - 0x000C-0x000F table write, 2 cycles, four pointer modes
// - Port modified from itself reads pin levels, not the latch
// - Write to timer zero with d=1 clears an assigned prescaler
`timescale 1ns/10ps
module cltd_decoder
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Fetch side
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [20:0] pc_i,
  // Core status and context
  input wire logic [4:0] status_i,
  input wire logic port_self_src_i,
  input wire logic prescaler_assigned_i,
  // Decoded result
  output logic dec_valid_o,
  output cltd_pkg::cltd_dec_t dec_o,
  output logic [20:0] branch_target_o,
  output logic branch_taken_o,
  output logic idle_cycle_o,
  output logic use_pins_o,
  output logic clear_prescaler_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  logic rst_n;
  assign rst_n = rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode
  typedef enum logic [1:0] {CLTD_S_FIRST, CLTD_S_SECOND, CLTD_S_IDLE}
    cltd_state_t;
  cltd_state_t state_q;
  cltd_state_t state_d;
  cltd_pkg::cltd_dec_t held_q;
  cltd_pkg::cltd_dec_t held_d;
  cltd_pkg::cltd_dec_t dec_q;
  cltd_pkg::cltd_dec_t dec_d;
  logic valid_q;
  logic valid_d;
  logic [20:0] tgt_q;
  logic [20:0] tgt_d;
  logic taken_q;
  logic taken_d;
  logic idle_q;
  logic idle_d;
  logic pins_q;
  logic pins_d;
  logic clr_q;
  logic clr_d;
  cltd_pkg::cltd_dec_t d;
  logic cond;
  logic [7:0] hi;

  always_comb
  begin
    hi = instr_i[15:8];
    d = '0;
    d.op = cltd_pkg::CLTD_NO_OPERATION;
    d.cycles = cltd_pkg::CYCLES_ONE;
    d.literal = instr_i[7:0];
    cond = 1'b0;
    if (instr_i[15:12] == cltd_pkg::OP_SECOND_WORD)
      d.op = cltd_pkg::CLTD_NO_OPERATION;
    else if (instr_i[15:9] == cltd_pkg::OP_CALL_HI)
    begin
      d.op = cltd_pkg::CLTD_CALL;
      d.shadow = instr_i[8];
      d.cycles = cltd_pkg::CYCLES_TWO;
      d.target = {12'h000, instr_i[7:0]};
    end
    else if (instr_i[15:11] == cltd_pkg::OP_BRANCH_HI)
    begin
      d.op = cltd_pkg::CLTD_BRANCH;
      // Bits 10:9 pick the flag, bit 8 asks for its inverse
      case (instr_i[10:9])
        2'h0: cond = status_i[cltd_pkg::FLAG_Z];
        2'h1: cond = status_i[cltd_pkg::FLAG_C];
        2'h2: cond = status_i[cltd_pkg::FLAG_OV];
        default: cond = status_i[cltd_pkg::FLAG_N];
      endcase
      cond = cond ^ instr_i[8];
      if (cond)
        d.cycles = cltd_pkg::CYCLES_TWO;
    end
    else if (instr_i == cltd_pkg::OP_POP)
      d.op = cltd_pkg::CLTD_POP;
    else if (instr_i == cltd_pkg::OP_PUSH)
      d.op = cltd_pkg::CLTD_PUSH;
    else if (instr_i == cltd_pkg::OP_SLEEP)
    begin
      d.op = cltd_pkg::CLTD_STANDBY;
      d.flags[cltd_pkg::FLAG_TIMEOUT] = 1'b1;
      d.flags[cltd_pkg::FLAG_POWER_DOWN] = 1'b1;
    end
    else if (instr_i[15:1] == cltd_pkg::OP_IRQ_RETURN_HI)
    begin
      d.op = cltd_pkg::CLTD_RETURN_FROM_INTERRUPT;
      d.shadow = instr_i[0];
      d.irq_reenable = 1'b1;
      d.flags[cltd_pkg::FLAG_IRQ] = 1'b1;
      d.cycles = cltd_pkg::CYCLES_TWO;
    end
    else if (instr_i[15:1] == cltd_pkg::OP_RETURN_HI)
    begin
      d.op = cltd_pkg::CLTD_RETURN;
      d.shadow = instr_i[0];
      d.cycles = cltd_pkg::CYCLES_TWO;
    end
    else if (instr_i[15:3] == cltd_pkg::OP_TABLE_HI)
    begin
      d.op = instr_i[2] ? cltd_pkg::CLTD_TABLE_WRITE
                        : cltd_pkg::CLTD_TABLE_READ;
      d.ptr_mode = cltd_pkg::cltd_ptr_t'(instr_i[1:0]);
      d.cycles = cltd_pkg::CYCLES_TWO;
    end
    else
    begin
      case (hi)
        cltd_pkg::OP_RETURN_LITERAL:
        begin
          d.op = cltd_pkg::CLTD_RETURN_WITH_LITERAL;
          d.cycles = cltd_pkg::CYCLES_TWO;
        end
        cltd_pkg::OP_AND_LITERAL: d.op = cltd_pkg::CLTD_AND_LITERAL;
        cltd_pkg::OP_OR_LITERAL: d.op = cltd_pkg::CLTD_OR_LITERAL;
        cltd_pkg::OP_XOR_LITERAL: d.op = cltd_pkg::CLTD_XOR_LITERAL;
        cltd_pkg::OP_SUB_LITERAL:
        begin
          d.op = cltd_pkg::CLTD_SUBTRACT_FROM_LITERAL;
          d.flags[4:0] = 5'h1f;
        end
        cltd_pkg::OP_MUL_LITERAL:
          d.op = cltd_pkg::CLTD_MULTIPLY_LITERAL;
        cltd_pkg::OP_LOAD_LITERAL:
          d.op = cltd_pkg::CLTD_LOAD_LITERAL;
        default: d.op = cltd_pkg::CLTD_NO_OPERATION;
      endcase
      if (hi == cltd_pkg::OP_AND_LITERAL || hi == cltd_pkg::OP_OR_LITERAL ||
          hi == cltd_pkg::OP_XOR_LITERAL)
      begin
        d.flags[cltd_pkg::FLAG_Z] = 1'b1;
        d.flags[cltd_pkg::FLAG_N] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: call second word and idle second cycles
  always_comb
  begin
    state_d = state_q;
    held_d = held_q;
    dec_d = dec_q;
    valid_d = 1'b0;
    tgt_d = tgt_q;
    taken_d = 1'b0;
    idle_d = 1'b0;
    // Port self-modify and timer clear are byte-op qualifiers from the core
    pins_d = instr_valid_i & port_self_src_i;
    clr_d = instr_valid_i & (instr_i[7:0] == cltd_pkg::TIMER_ZERO_ADDR)
          & instr_i[9] & prescaler_assigned_i;
    case (state_q)
      CLTD_S_FIRST:
        if (instr_valid_i)
        begin
          if (d.op == cltd_pkg::CLTD_CALL)
          begin
            held_d = d;
            state_d = CLTD_S_SECOND;
          end
          else
          begin
            dec_d = d;
            valid_d = 1'b1;
            if (d.op == cltd_pkg::CLTD_BRANCH &&
                d.cycles == cltd_pkg::CYCLES_TWO)
            begin
              tgt_d = pc_i + 21'h00_0002
                    + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
              taken_d = 1'b1;
            end
            if (d.cycles == cltd_pkg::CYCLES_TWO)
              state_d = CLTD_S_IDLE;
          end
        end
      CLTD_S_SECOND:
        if (instr_valid_i)
        begin
          dec_d = held_q;
          dec_d.target = {instr_i[11:0], held_q.target[7:0]};
          valid_d = 1'b1;
          tgt_d = {instr_i[11:0], held_q.target[7:0], 1'b0};
          taken_d = 1'b1;
          state_d = CLTD_S_IDLE;
        end
      CLTD_S_IDLE:
      begin
        idle_d = 1'b1;
        dec_d = '0;
        dec_d.op = cltd_pkg::CLTD_NO_OPERATION;
        dec_d.cycles = cltd_pkg::CYCLES_ONE;
        valid_d = 1'b1;
        pins_d = 1'b0;
        clr_d = 1'b0;
        state_d = CLTD_S_FIRST;
      end
      default: state_d = CLTD_S_FIRST;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CLTD_S_FIRST;
      held_q <= '0;
      dec_q <= '0;
      valid_q <= 1'b0;
      tgt_q <= '0;
      taken_q <= 1'b0;
      idle_q <= 1'b0;
      pins_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      held_q <= held_d;
      dec_q <= dec_d;
      valid_q <= valid_d;
      tgt_q <= tgt_d;
      taken_q <= taken_d;
      idle_q <= idle_d;
      pins_q <= pins_d;
      clr_q <= clr_d;
    end
  end

  assign dec_valid_o = valid_q;
  assign dec_o = dec_q;
  assign branch_target_o = tgt_q;
  assign branch_taken_o = taken_q;
  assign idle_cycle_o = idle_q;
  assign use_pins_o = pins_q;
  assign clear_prescaler_o = clr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  taken_then_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    taken_q |=> idle_q) else $error("taken without idle cycle");
  call_two_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i &&
     instr_i[15:9] == cltd_pkg::OP_CALL_HI) |=> !valid_q)
    else $error("call decoded in one word");
  lone_second_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i[15:12] == 4'hf)
    |=> dec_q.op == cltd_pkg::CLTD_NO_OPERATION)
    else $error("lone second word not idle");
  pop_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i == 16'h0006)
    |=> dec_q.op == cltd_pkg::CLTD_POP && dec_q.flags == 8'h00
    ##1 !idle_q) else $error("pop wrong");
  push_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i == 16'h0005)
    |=> dec_q.op == cltd_pkg::CLTD_PUSH ##1 !idle_q)
    else $error("push wrong");
  irq_return_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i[15:1] == 15'h0008)
    |=> dec_q.irq_reenable ##1 idle_q)
    else $error("interrupt return wrong");
  sleep_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i == 16'h0003)
    |=> dec_q.flags == 8'h60) else $error("standby flags");
  table_two_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i[15:3] == 13'h0001)
    |=> dec_q.cycles == 2'h2 ##1 idle_q) else $error("table cycles");
  sub_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state_q == CLTD_S_FIRST && instr_valid_i && instr_i[15:8] == 8'h08)
    |=> dec_q.flags == 8'h1f) else $error("subtract flags");

endmodule : cltd_decoder

// *** verification/control_literal_table_decoder_bench.sv ***
// Self-checking bench for the control, literal and table decoder
`timescale 1ns/10ps
module control_literal_table_decoder_bench;
  //////////////////////////////////////////////////////////////////////////
  logic mclk_i;
  logic reset_n_i;
  logic instr_valid_i;
  logic [15:0] instr_i;
  logic [20:0] pc_i;
  logic [4:0] status_i;
  logic port_self_src_i;
  logic prescaler_assigned_i;
  logic dec_valid_o;
  cltd_pkg::cltd_dec_t dec_o;
  logic [20:0] branch_target_o;
  logic branch_taken_o;
  logic idle_cycle_o;
  logic use_pins_o;
  logic clear_prescaler_o;
  int miscompares;
  int samples_checked;
  cltd_pkg::cltd_op_t e_op;
  logic [1:0] e_cyc;
  logic [7:0] e_flags;
  logic e_taken;
  logic [20:0] e_target;
  logic [15:0] w;
  // Flag tested by each branch condition pair
  localparam int FIDX [4] = '{cltd_pkg::FLAG_Z, cltd_pkg::FLAG_C,
    cltd_pkg::FLAG_OV, cltd_pkg::FLAG_N};

  cltd_decoder DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
    .status_i(status_i), .port_self_src_i(port_self_src_i),
    .prescaler_assigned_i(prescaler_assigned_i), .dec_valid_o(dec_valid_o),
    .dec_o(dec_o), .branch_target_o(branch_target_o),
    .branch_taken_o(branch_taken_o), .idle_cycle_o(idle_cycle_o),
    .use_pins_o(use_pins_o), .clear_prescaler_o(clear_prescaler_o));

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic cmpv(input logic [20:0] g, input logic [20:0] e,
                      input string m);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h w %h", $time, m, g, e, w);
    end
  endtask : cmpv

  task automatic cmp1(input logic g, input logic e, input string m);
    cmpv({20'h0_0000, g}, {20'h0_0000, e}, m);
  endtask : cmp1

  task automatic se(input cltd_pkg::cltd_op_t o, input logic [1:0] c,
                    input logic [7:0] f);
    e_op = o;
    e_cyc = c;
    e_flags = f;
  endtask : se

  // Expected decode, worked out from the opcode map alone
  task automatic predict(input logic [15:0] x);
    e_taken = 1'b0;
    e_target = pc_i + 21'h0_0002 + {{12{x[7]}}, x[7:0], 1'b0};
    if (x[15:12] == 4'hf)
      se(cltd_pkg::CLTD_NO_OPERATION, 2'h1, 8'h00);
    else if (x[15:11] == 5'h1c)
    begin
      e_taken = status_i[FIDX[x[10:9]]] ^ x[8];
      se(cltd_pkg::CLTD_BRANCH, e_taken ? 2'h2 : 2'h1, 8'h00);
    end
    else if (x == 16'h0003)
      se(cltd_pkg::CLTD_STANDBY, 2'h1, 8'h60);
    else if (x == 16'h0005)
      se(cltd_pkg::CLTD_PUSH, 2'h1, 8'h00);
    else if (x == 16'h0006)
      se(cltd_pkg::CLTD_POP, 2'h1, 8'h00);
    else if (x[15:1] == 15'h0008)
      se(cltd_pkg::CLTD_RETURN_FROM_INTERRUPT, 2'h2, 8'h80);
    else if (x[15:1] == 15'h0009)
      se(cltd_pkg::CLTD_RETURN, 2'h2, 8'h00);
    else if (x[15:2] == 14'h0002)
      se(cltd_pkg::CLTD_TABLE_READ, 2'h2, 8'h00);
    else if (x[15:2] == 14'h0003)
      se(cltd_pkg::CLTD_TABLE_WRITE, 2'h2, 8'h00);
    else
      case (x[15:8])
        8'h0c: se(cltd_pkg::CLTD_RETURN_WITH_LITERAL, 2'h2, 8'h00);
        8'h0b: se(cltd_pkg::CLTD_AND_LITERAL, 2'h1, 8'h14);
        8'h09: se(cltd_pkg::CLTD_OR_LITERAL, 2'h1, 8'h14);
        8'h0a: se(cltd_pkg::CLTD_XOR_LITERAL, 2'h1, 8'h14);
        8'h08: se(cltd_pkg::CLTD_SUBTRACT_FROM_LITERAL, 2'h1, 8'h1f);
        8'h0d: se(cltd_pkg::CLTD_MULTIPLY_LITERAL, 2'h1, 8'h00);
        8'h0e: se(cltd_pkg::CLTD_LOAD_LITERAL, 2'h1, 8'h00);
        default: se(cltd_pkg::CLTD_NO_OPERATION, 2'h1, 8'h00);
      endcase
  endtask : predict

  //////////////////////////////////////////////////////////////////////////
  // Inputs change only at the falling edge; results read at the next falling edge
  task automatic issue(input logic v, input logic [15:0] x);
    instr_valid_i = v;
    instr_i = x;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : issue

  // A word offered during the idle cycle must leave no trace
  task automatic run_word(input logic [15:0] x, input logic iv);
    w = x;
    predict(x);
    issue(1'b1, x);
    cmp1(dec_valid_o, 1'b1, "valid");
    cmpv(21'(dec_o.op), 21'(e_op), "op");
    cmpv(21'(dec_o.cycles), 21'(e_cyc), "cycles");
    cmpv(21'(dec_o.flags), 21'(e_flags), "flags");
    cmp1(branch_taken_o, e_taken, "taken");
    if (e_taken)
      cmpv(branch_target_o, e_target, "target");
    if (x[15:11] == 5'h01 && x[10:8] != 3'h7)
      cmpv(21'(dec_o.literal), 21'(x[7:0]), "literal");
    if (x[15:3] == 13'h0001)
      cmpv(21'(dec_o.ptr_mode), 21'(x[1:0]), "ptr");
    if (x[15:2] == 14'h0004)
      cmp1(dec_o.shadow, x[0], "shadow");
    cmp1(dec_o.irq_reenable, x[15:1] == 15'h0008, "irq");
    if (e_cyc == cltd_pkg::CYCLES_TWO)
    begin
      issue(iv, 16'h0e5a);
      cmp1(idle_cycle_o, 1'b1, "idle");
      cmp1(dec_valid_o && dec_o.op == cltd_pkg::CLTD_LOAD_LITERAL, 1'b0,
           "idle word taken");
    end
    else if ($urandom_range(0, 1) == 1)
    begin
      issue(1'b0, 16'h0000);
      cmp1(idle_cycle_o, 1'b0, "idle");
    end
  endtask : run_word

  task automatic run_call(input logic [19:0] k, input logic s);
    w = {7'h76, s, k[7:0]};
    issue(1'b1, w);
    cmp1(dec_valid_o, 1'b0, "early");
    issue(1'b1, {4'hf, k[19:8]});
    cmp1(dec_valid_o, 1'b1, "valid");
    cmpv(21'(dec_o.op), 21'(cltd_pkg::CLTD_CALL), "op");
    cmpv(21'(dec_o.cycles), 21'(cltd_pkg::CYCLES_TWO), "cycles");
    cmp1(dec_o.shadow, s, "shadow");
    cmpv(21'(dec_o.target), 21'(k), "target");
    cmpv(branch_target_o, {k, 1'b0}, "pc");
    issue(1'b0, 16'h0000);
    cmp1(idle_cycle_o, 1'b1, "idle");
  endtask : run_call

  task automatic run_side(input logic [15:0] x, input logic ps,
                          input logic pa, input logic ep, input logic ec);
    // Qualifiers stand for one cycle, so look right after the word
    port_self_src_i = ps;
    prescaler_assigned_i = pa;
    w = x;
    predict(x);
    issue(1'b1, x);
    cmp1(use_pins_o, ep, "pins");
    cmp1(clear_prescaler_o, ec, "prescaler");
    cmpv(21'(dec_o.op), 21'(e_op), "op");
    issue(1'b0, 16'h0000);
    cmp1(use_pins_o, 1'b0, "pins held");
    cmp1(clear_prescaler_o, 1'b0, "prescaler held");
  endtask : run_side

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(37778));
    reset_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    pc_i = 21'h0_0100;
    status_i = 5'h00;
    port_self_src_i = 1'b0;
    prescaler_assigned_i = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    w = 16'h0000;
    repeat (6) @(negedge mclk_i);
    cmp1(dec_valid_o, 1'b0, "reset");
    reset_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    for (int i = 0; i < 32; i++)
      run_word({8'h00, 8'(i)}, i[0]);
    for (int i = 8; i < 15; i++)
      run_word({8'(i), 8'(8'ha5 + i)}, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      status_i = i[3] ? 5'h1f : 5'h00;
      run_word({5'h1c, 3'(i), 8'h80}, 1'b1);
    end
    run_word(16'hf123, 1'b0);
    run_call(20'hf_ffff, 1'b1);
    run_call(20'h1_2345, 1'b0);
    run_side(16'h52c4, 1'b1, 1'b0, 1'b1, 1'b0);
    run_side(16'h52c4, 1'b0, 1'b0, 1'b0, 1'b0);
    run_side(16'h26d6, 1'b0, 1'b1, 1'b0, 1'b1);
    run_side(16'h24d6, 1'b0, 1'b1, 1'b0, 1'b0);
    run_side(16'h26d6, 1'b0, 1'b0, 1'b0, 1'b0);
    prescaler_assigned_i = 1'b0;
    for (int n = 0; n < 400; n++)
    begin
      status_i = 5'($urandom);
      pc_i = {20'($urandom), 1'b0};
      case ($urandom_range(0, 3))
        0: w = 16'($urandom);
        1: w = {8'(8 + $urandom_range(0, 6)), 8'($urandom)};
        2: w = {11'h000, 5'($urandom)};
        default: w = {5'h1c, 11'($urandom)};
      endcase
      // Lone call words would need a partner word, so they become spares
      if (w[15:9] == 7'h76)
        w[15:12] = 4'hf;
      run_word(w, 1'($urandom));
    end
    tally_and_finish();
  end
endmodule : control_literal_table_decoder_bench
